// ==== core/lsc_decode.sv ====
/*
  lsc_decode: decode and timing for bit tests, disjunctions, invert,
  string operations with iteration prefix, and indirect near invoke.
  Assumes the fetch unit presents prefix, opcode and modrm together with
  a start pulse, and the datapath returns the zero flag per element.
*/
`default_nettype none

module lsc_decode #(
  parameter int CW = 16
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  input  wire logic          i_start,
  input  wire logic          i_prefix_valid,
  input  wire logic [7:0]    i_prefix,
  input  wire logic [7:0]    i_opcode,
  input  wire logic [7:0]    i_modrm,
  input  wire logic [CW-1:0] i_count,
  input  wire logic          i_zero_flag,
  output logic               o_busy,
  output logic               o_done,
  output logic               o_unsupported,
  output logic [3:0]         o_op,
  output logic [2:0]         o_form,
  output logic               o_word,
  output logic               o_reg_dest,
  output logic               o_mem_operand,
  output logic               o_flags_only,
  output logic [1:0]         o_imm_bytes,
  output logic [1:0]         o_xfers,
  output logic               o_repeat,
  output logic               o_elem_strobe,
  output logic [CW-1:0]      o_count,
  output logic [15:0]        o_charged
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SETUP, ST_ELEM} lsc_state_type;

  // extra clocks for a number of word memory transfers
  function automatic logic [7:0] xfer_cycles(input logic [1:0] n);
    xfer_cycles = 8'(lsc_pkg::CLK_WORD_XFER * {6'h00, n});
  endfunction

  // word penalty, none for byte operands
  function automatic logic [7:0] word_extra(input logic w, input logic [1:0] n);
    word_extra = w ? xfer_cycles(n) : 8'h00;
  endfunction

  // ==========================================================
  // combinational decode
  lsc_pkg::lsc_op_type   dec_op;
  lsc_pkg::lsc_form_type dec_form;
  logic       dec_w;
  logic       dec_d;
  logic       dec_mem;
  logic       dec_flags;
  logic [1:0] dec_imm;
  logic [1:0] dec_xfers;
  logic [7:0] dec_base;
  logic [7:0] dec_set;
  logic [7:0] dec_el;
  logic       dec_rep;
  logic [2:0] sub;

  always_comb
  begin
    sub       = i_modrm[5:3];
    dec_op    = lsc_pkg::OP_NONE;
    dec_form  = lsc_pkg::FORM_NONE;
    dec_w     = i_opcode[0];
    dec_d     = 1'b0;
    dec_mem   = (i_modrm[7:6] != lsc_pkg::MOD_REGISTER);
    dec_flags = 1'b0;
    dec_imm   = 2'h0;
    dec_xfers = 2'h0;
    dec_base  = 8'h00;
    dec_set   = 8'h00;
    dec_el    = 8'h00;
    if (i_opcode[7:1] == lsc_pkg::OPC_TEST_RM)
    begin
      dec_op    = lsc_pkg::OP_TEST;
      dec_form  = lsc_pkg::FORM_RM_REG;
      dec_flags = 1'b1;
      dec_xfers = {1'b0, dec_mem};
      dec_base  = dec_mem ? lsc_pkg::CLK_RM_MEM : lsc_pkg::CLK_RM_REG;
    end
    else if ((i_opcode[7:1] == lsc_pkg::OPC_GROUP3) && (sub == lsc_pkg::SUB_TEST))
    begin
      dec_op    = lsc_pkg::OP_TEST;
      dec_form  = lsc_pkg::FORM_IMM_RM;
      dec_flags = 1'b1;
      dec_imm   = dec_w ? 2'h2 : 2'h1;
      dec_xfers = {1'b0, dec_mem};
      dec_base  = dec_mem ? lsc_pkg::CLK_TEST_IMEM : lsc_pkg::CLK_IMM_REG;
    end
    else if ((i_opcode[7:1] == lsc_pkg::OPC_GROUP3) && (sub == lsc_pkg::SUB_NOT))
    begin
      dec_op    = lsc_pkg::OP_NOT;
      dec_form  = lsc_pkg::FORM_RM_ONLY;
      dec_xfers = dec_mem ? 2'h2 : 2'h0;
      dec_base  = dec_mem ? lsc_pkg::CLK_RM_MEM : lsc_pkg::CLK_RM_REG;
    end
    else if ((i_opcode[7:1] == lsc_pkg::OPC_TEST_ACC) ||
             (i_opcode[7:1] == lsc_pkg::OPC_OR_ACC) ||
             (i_opcode[7:1] == lsc_pkg::OPC_XOR_ACC))
    begin
      dec_op    = (i_opcode[7:1] == lsc_pkg::OPC_TEST_ACC) ? lsc_pkg::OP_TEST :
                  (i_opcode[7:1] == lsc_pkg::OPC_OR_ACC) ? lsc_pkg::OP_OR :
                  lsc_pkg::OP_XOR;
      dec_form  = lsc_pkg::FORM_IMM_ACC;
      dec_flags = (i_opcode[7:1] == lsc_pkg::OPC_TEST_ACC);
      dec_mem   = 1'b0;
      dec_imm   = dec_w ? 2'h2 : 2'h1;
      dec_base  = dec_w ? lsc_pkg::CLK_ACC_WORD : lsc_pkg::CLK_ACC_BYTE;
    end
    else if ((i_opcode[7:2] == lsc_pkg::OPC_OR_RM) ||
             (i_opcode[7:2] == lsc_pkg::OPC_XOR_RM))
    begin
      dec_op    = (i_opcode[7:2] == lsc_pkg::OPC_OR_RM) ? lsc_pkg::OP_OR : lsc_pkg::OP_XOR;
      dec_form  = lsc_pkg::FORM_RM_REG;
      dec_d     = i_opcode[1];
      dec_xfers = (dec_mem && !dec_d) ? 2'h2 : {1'b0, dec_mem};
      dec_base  = dec_mem ? lsc_pkg::CLK_RM_MEM : lsc_pkg::CLK_RM_REG;
    end
    else if ((i_opcode[7:1] == lsc_pkg::OPC_GROUP1) &&
             ((sub == lsc_pkg::SUB_OR) || (sub == lsc_pkg::SUB_XOR)))
    begin
      dec_op    = (sub == lsc_pkg::SUB_OR) ? lsc_pkg::OP_OR : lsc_pkg::OP_XOR;
      dec_form  = lsc_pkg::FORM_IMM_RM;
      dec_imm   = dec_w ? 2'h2 : 2'h1;
      dec_xfers = dec_mem ? 2'h2 : 2'h0;
      dec_base  = dec_mem ? lsc_pkg::CLK_LOGIC_IMEM : lsc_pkg::CLK_IMM_REG;
    end
    else if ((i_opcode == lsc_pkg::OPC_GROUP5) && (sub == lsc_pkg::SUB_CALL_IND))
    begin
      // indirect near invoke: push, plus a target read when the operand is in memory
      dec_op    = lsc_pkg::OP_CALL;
      dec_form  = lsc_pkg::FORM_INDIRECT;
      dec_w     = 1'b1;
      dec_xfers = dec_mem ? 2'h2 : 2'h1;
      dec_base  = dec_mem ? lsc_pkg::CLK_CALL_MEM : lsc_pkg::CLK_CALL_REG;
    end
    else
    begin
      dec_form = lsc_pkg::FORM_STRING;
      dec_mem  = 1'b1;
      case (i_opcode[7:1])
        lsc_pkg::OPC_MOVE:
        begin
          dec_op = lsc_pkg::OP_MOVE;  dec_xfers = 2'h2; dec_base = lsc_pkg::CLK_MOVE;
          dec_set = lsc_pkg::REP_MOVE_SET; dec_el = lsc_pkg::REP_MOVE_EL;
        end
        lsc_pkg::OPC_COMPARE:
        begin
          dec_op = lsc_pkg::OP_COMPARE; dec_xfers = 2'h2; dec_base = lsc_pkg::CLK_COMPARE;
          dec_flags = 1'b1; dec_set = lsc_pkg::REP_CMP_SET; dec_el = lsc_pkg::REP_CMP_EL;
        end
        lsc_pkg::OPC_SCAN:
        begin
          dec_op = lsc_pkg::OP_SCAN; dec_xfers = 2'h1; dec_base = lsc_pkg::CLK_SCAN;
          dec_flags = 1'b1; dec_set = lsc_pkg::REP_SCAN_SET; dec_el = lsc_pkg::REP_SCAN_EL;
        end
        lsc_pkg::OPC_LOAD:
        begin
          dec_op = lsc_pkg::OP_LOAD; dec_xfers = 2'h1; dec_base = lsc_pkg::CLK_LOAD;
          dec_set = lsc_pkg::REP_LOAD_SET; dec_el = lsc_pkg::REP_LOAD_EL;
        end
        lsc_pkg::OPC_STORE:
        begin
          dec_op = lsc_pkg::OP_STORE; dec_xfers = 2'h1; dec_base = lsc_pkg::CLK_STORE;
          dec_set = lsc_pkg::REP_STORE_SET; dec_el = lsc_pkg::REP_STORE_EL;
        end
        lsc_pkg::OPC_PORT_IN:
        begin
          dec_op = lsc_pkg::OP_PORT_IN; dec_xfers = 2'h1; dec_base = lsc_pkg::CLK_PORT_IN;
          dec_set = lsc_pkg::REP_PORT_SET; dec_el = lsc_pkg::REP_PORT_EL;
        end
        lsc_pkg::OPC_PORT_OUT:
        begin
          dec_op = lsc_pkg::OP_PORT_OUT; dec_xfers = 2'h1; dec_base = lsc_pkg::CLK_PORT_OUT;
          dec_set = lsc_pkg::REP_PORT_SET; dec_el = lsc_pkg::REP_PORT_EL;
        end
        default:
        begin
          dec_form = lsc_pkg::FORM_NONE;
          dec_mem  = 1'b0;
        end
      endcase
    end
    // prefix applies to string forms only
    dec_rep = i_prefix_valid && (i_prefix[7:1] == lsc_pkg::OPC_ITER_PFX) &&
              (dec_form == lsc_pkg::FORM_STRING);
  end

  // ==========================================================
  // sequencing state
  lsc_state_type st;
  lsc_state_type next_st;
  logic          load;
  logic [7:0]    load_val;
  logic          seg_last;
  logic          rep_z;
  logic          next_rep_z;
  logic [7:0]    el_cost;
  logic [7:0]    next_el_cost;
  logic          next_busy;
  logic          next_done;
  logic          next_unsup;
  logic          next_strobe;
  logic [CW-1:0] next_count;
  logic [15:0]   next_charged;
  logic [3:0]    next_op;
  logic [2:0]    next_form;
  logic [8:0]    next_flags;

  lsc_timer #(.W(8)) u_timer (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_load  (load),
    .i_value (load_val),
    .o_last  (seg_last)
  );

  // next state, timer loads and output values
  always_comb
  begin
    next_st      = st;
    load         = 1'b0;
    load_val     = 8'h00;
    next_rep_z   = rep_z;
    next_el_cost = el_cost;
    next_busy    = o_busy;
    next_done    = 1'b0;
    next_unsup   = 1'b0;
    next_strobe  = 1'b0;
    next_count   = o_count;
    next_charged = o_busy ? o_charged + 16'h0001 : o_charged;
    next_op      = o_op;
    next_form    = o_form;
    next_flags   = {o_word, o_reg_dest, o_mem_operand, o_flags_only, o_imm_bytes,
                    o_xfers, o_repeat};
    case (st)
      ST_IDLE:
        if (i_start && (dec_op == lsc_pkg::OP_NONE))
          next_unsup = 1'b1;
        else if (i_start)
        begin
          next_busy    = 1'b1;
          next_charged = 16'h0000;
          next_op      = dec_op;
          next_form    = dec_form;
          next_flags   = {dec_w, dec_d, dec_mem, dec_flags, dec_imm, dec_xfers, dec_rep};
          next_count   = i_count;
          next_rep_z   = i_prefix[0];
          next_el_cost = dec_el + word_extra(dec_w, dec_xfers);
          load         = 1'b1;
          if (dec_rep)
          begin
            load_val = dec_set;
            next_st  = ST_SETUP;
          end
          else
          begin
            load_val = dec_base + word_extra(dec_w, dec_xfers);
            next_st  = ST_RUN;
          end
        end
      ST_RUN:
        if (seg_last)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st   = ST_IDLE;
        end
      ST_SETUP:
        if (seg_last && (o_count == '0))
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st   = ST_IDLE;
        end
        else if (seg_last)
        begin
          load     = 1'b1;
          load_val = el_cost;
          next_st  = ST_ELEM;
        end
      ST_ELEM:
        if (seg_last)
        begin
          next_strobe = 1'b1;
          next_count  = o_count - CW'(1);
          // count exhausted, or for compare and scan the zero flag differs from z
          if ((o_count == CW'(1)) ||
              (((o_op == lsc_pkg::OP_COMPARE) || (o_op == lsc_pkg::OP_SCAN)) &&
               (i_zero_flag != rep_z)))
          begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_st   = ST_IDLE;
          end
          else
          begin
            load     = 1'b1;
            load_val = el_cost;
          end
        end
      default:
        next_st = ST_IDLE;
    endcase
  end

  // register state and outputs
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      st            <= ST_IDLE;
      rep_z         <= 1'b0;
      el_cost       <= 8'h00;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
      o_unsupported <= 1'b0;
      o_elem_strobe <= 1'b0;
      o_count       <= '0;
      o_charged     <= 16'h0000;
      o_op          <= 4'h0;
      o_form        <= 3'h0;
      {o_word, o_reg_dest, o_mem_operand, o_flags_only, o_imm_bytes, o_xfers,
       o_repeat}    <= 9'h000;
    end
    else
    begin
      st            <= next_st;
      rep_z         <= next_rep_z;
      el_cost       <= next_el_cost;
      o_busy        <= next_busy;
      o_done        <= next_done;
      o_unsupported <= next_unsup;
      o_elem_strobe <= next_strobe;
      o_count       <= next_count;
      o_charged     <= next_charged;
      o_op          <= next_op;
      o_form        <= next_form;
      {o_word, o_reg_dest, o_mem_operand, o_flags_only, o_imm_bytes, o_xfers,
       o_repeat}    <= next_flags;
    end
  end

endmodule // lsc_decode

`default_nettype wire

// ==== core/lsc_pkg.sv ====
/*
  lsc_pkg: opcode patterns, sub-opcode codes, clock counts and operation
  classes shared by the logic/string/call decoder.
  Assumes a byte-wide instruction stream and a single core clock.
*/
`default_nettype none

package lsc_pkg;

  // ==========================================================
  // opcode patterns (upper bits, low w, dw or z bits dropped; OPC_GROUP5 full byte)
  localparam logic [6:0] OPC_TEST_RM   = 7'h42; // 1000010w
  localparam logic [6:0] OPC_GROUP3    = 7'h7B; // 1111011w
  localparam logic [6:0] OPC_TEST_ACC  = 7'h54; // 1010100w
  localparam logic [5:0] OPC_OR_RM     = 6'h02; // 000010dw
  localparam logic [6:0] OPC_GROUP1    = 7'h40; // 1000000w
  localparam logic [6:0] OPC_OR_ACC    = 7'h06; // 0000110w
  localparam logic [5:0] OPC_XOR_RM    = 6'h0C; // 001100dw
  localparam logic [6:0] OPC_XOR_ACC   = 7'h1A; // 0011010w
  localparam logic [6:0] OPC_MOVE      = 7'h52; // 1010010w
  localparam logic [6:0] OPC_COMPARE   = 7'h53; // 1010011w
  localparam logic [6:0] OPC_SCAN      = 7'h57; // 1010111w
  localparam logic [6:0] OPC_LOAD      = 7'h56; // 1010110w
  localparam logic [6:0] OPC_STORE     = 7'h55; // 1010101w
  localparam logic [6:0] OPC_PORT_IN   = 7'h36; // 0110110w
  localparam logic [6:0] OPC_PORT_OUT  = 7'h37; // 0110111w
  localparam logic [6:0] OPC_ITER_PFX  = 7'h79; // 1111001z
  localparam logic [7:0] OPC_GROUP5    = 8'hFF; // 11111111

  // ==========================================================
  // modrm fields
  localparam logic [1:0] MOD_REGISTER  = 2'h3;
  localparam logic [2:0] SUB_TEST      = 3'h0;
  localparam logic [2:0] SUB_OR        = 3'h1;
  localparam logic [2:0] SUB_NOT       = 3'h2;
  localparam logic [2:0] SUB_XOR       = 3'h6;
  localparam logic [2:0] SUB_CALL_IND  = 3'h2;

  // ==========================================================
  // clock counts (byte operands, CLK_ACC_WORD for the word accumulator form)
  localparam logic [7:0] CLK_RM_REG    = 8'h03;
  localparam logic [7:0] CLK_RM_MEM    = 8'h0A;
  localparam logic [7:0] CLK_IMM_REG   = 8'h04;
  localparam logic [7:0] CLK_TEST_IMEM = 8'h0A;
  localparam logic [7:0] CLK_LOGIC_IMEM= 8'h10;
  localparam logic [7:0] CLK_ACC_BYTE  = 8'h03;
  localparam logic [7:0] CLK_ACC_WORD  = 8'h04;
  localparam logic [7:0] CLK_MOVE      = 8'h0E;
  localparam logic [7:0] CLK_COMPARE   = 8'h16;
  localparam logic [7:0] CLK_SCAN      = 8'h0F;
  localparam logic [7:0] CLK_LOAD      = 8'h0C;
  localparam logic [7:0] CLK_STORE     = 8'h0A;
  localparam logic [7:0] CLK_PORT_IN   = 8'h0E;
  localparam logic [7:0] CLK_PORT_OUT  = 8'h0E;
  localparam logic [7:0] CLK_CALL_REG  = 8'h11;
  localparam logic [7:0] CLK_CALL_MEM  = 8'h1B;
  localparam logic [7:0] CLK_WORD_XFER = 8'h04; // per memory transfer
  // repeated forms: setup, then per element
  localparam logic [7:0] REP_MOVE_SET  = 8'h08;
  localparam logic [7:0] REP_MOVE_EL   = 8'h08;
  localparam logic [7:0] REP_CMP_SET   = 8'h05;
  localparam logic [7:0] REP_CMP_EL    = 8'h16;
  localparam logic [7:0] REP_SCAN_SET  = 8'h05;
  localparam logic [7:0] REP_SCAN_EL   = 8'h0F;
  localparam logic [7:0] REP_LOAD_SET  = 8'h06;
  localparam logic [7:0] REP_LOAD_EL   = 8'h0B;
  localparam logic [7:0] REP_STORE_SET = 8'h06;
  localparam logic [7:0] REP_STORE_EL  = 8'h09;
  localparam logic [7:0] REP_PORT_SET  = 8'h08;
  localparam logic [7:0] REP_PORT_EL   = 8'h08;

  // ==========================================================
  // operation classes and operand forms
  typedef enum logic [3:0] {
    OP_NONE, OP_TEST, OP_OR, OP_XOR, OP_NOT, OP_MOVE, OP_COMPARE, OP_SCAN,
    OP_LOAD, OP_STORE, OP_PORT_IN, OP_PORT_OUT, OP_CALL
  } lsc_op_type;

  typedef enum logic [2:0] {
    FORM_NONE, FORM_RM_REG, FORM_IMM_RM, FORM_IMM_ACC, FORM_RM_ONLY,
    FORM_STRING, FORM_INDIRECT
  } lsc_form_type;

endpackage

`default_nettype wire

// ==== core/lsc_timer.sv ====
/*
  lsc_timer: loadable down counter that marks the last cycle of a segment.
  Assumes a load value of at least one; a load restarts the count.
*/
`default_nettype none

module lsc_timer #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_last
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // ==========================================================
  // count down towards zero
  always_comb
  begin
    next_cnt = cnt;
    if (i_load)
      next_cnt = i_value;
    else if (cnt != '0)
      next_cnt = cnt - W'(1);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign o_last = (cnt == W'(1)); // final cycle of the segment

endmodule // lsc_timer

`default_nettype wire

// ==== tb/lsc_decode_sva.sv ====
/*
  lsc_decode_sva: timing checks on the decoder ports.
  Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none

module lsc_decode_sva #(
  parameter int CW = 16
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  input  wire logic          i_start,
  input  wire logic          i_prefix_valid,
  input  wire logic [7:0]    i_opcode,
  input  wire logic [7:0]    i_modrm,
  input  wire logic          o_busy,
  input  wire logic          o_done,
  input  wire logic          o_unsupported,
  input  wire logic [3:0]    o_op,
  input  wire logic          o_word,
  input  wire logic          o_flags_only,
  input  wire logic          o_elem_strobe,
  input  wire logic [CW-1:0] o_count,
  input  wire logic [15:0]   o_charged
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic        taken;

  // ==========================================================
  // busy cycles since the last done
  always_comb
  begin
    next_busy_cnt = o_done ? 16'h0000 : busy_cnt + 16'(o_busy);
  end

  always_ff @(posedge i_mclk)
  begin
    busy_cnt <= i_rst_b ? next_busy_cnt : 16'h0000;
  end

  // start is accepted whenever no work runs, the done cycle included
  assign taken = i_start && !o_busy;
  sequence s_end;
    !o_busy && o_done;
  endsequence
  sequence s_busy3;
    o_busy [*3] ##1 s_end;
  endsequence

  a_done_after_busy: assert property ($fell(o_busy) |-> o_done)
    else $error("done missing after busy");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_start_taken: assert property (taken |=> o_busy || o_unsupported)
    else $error("start not answered");
  a_test_reg: assert property (taken && i_opcode[7:1] == lsc_pkg::OPC_TEST_RM
    && i_modrm[7:6] == lsc_pkg::MOD_REGISTER |=> s_busy3) else $error("test reg count");
  a_move_single: assert property (taken && !i_prefix_valid && i_opcode == 8'hA4
    |=> o_busy ##13 o_busy ##1 s_end) else $error("move count");
  a_charged_total: assert property (o_done |-> o_charged == busy_cnt)
    else $error("charged differs from busy time");
  a_count_step: assert property (o_elem_strobe |-> o_count == $past(o_count) - 1'b1)
    else $error("count not stepped");
  a_unsup_quiet: assert property (o_unsupported |-> !o_busy && !o_done)
    else $error("unsupported started work");
  a_flags_test: assert property (o_busy && o_op == lsc_pkg::OP_TEST |-> o_flags_only)
    else $error("test writes result");
  a_call_word: assert property (o_busy && o_op == lsc_pkg::OP_CALL |-> o_word)
    else $error("invoke not word");
endmodule // lsc_decode_sva

bind lsc_decode lsc_decode_sva #(.CW(CW)) i_sva (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_start(i_start), .i_prefix_valid(i_prefix_valid), .i_opcode(i_opcode),
  .i_modrm(i_modrm), .o_busy(o_busy), .o_done(o_done), .o_unsupported(o_unsupported),
  .o_op(o_op), .o_word(o_word), .o_flags_only(o_flags_only),
  .o_elem_strobe(o_elem_strobe), .o_count(o_count), .o_charged(o_charged));

`default_nettype wire

// ==== tb/lsc_decode_test.sv ====
/*
  lsc_decode_test: runs each form and checks charged clocks and fields.
  Assumes a 25 MHz clock and inputs driven 1 ns after the rising edge.
*/
`default_nettype none

module lsc_decode_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk, i_rst_b, i_start, i_prefix_valid, zf;
  logic [7:0] i_prefix, i_opcode, i_modrm, pattern;
  logic [15:0] i_count, o_count, o_charged;
  logic o_busy, o_done, o_unsupported, o_word, o_reg_dest, o_elem_strobe;
  logic [3:0] o_op;
  logic [2:0] o_form;
  logic [1:0] o_imm_bytes, o_xfers;
  logic o_mem_operand, o_flags_only, o_repeat;
  int bad_count = 0;
  int checks_done = 0;
  int poke = -1;

  lsc_decode i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_prefix_valid(i_prefix_valid), .i_prefix(i_prefix), .i_opcode(i_opcode),
    .i_modrm(i_modrm), .i_count(i_count), .i_zero_flag(zf), .o_busy(o_busy),
    .o_done(o_done), .o_unsupported(o_unsupported), .o_op(o_op), .o_form(o_form),
    .o_word(o_word), .o_reg_dest(o_reg_dest), .o_mem_operand(o_mem_operand),
    .o_flags_only(o_flags_only), .o_imm_bytes(o_imm_bytes), .o_xfers(o_xfers),
    .o_repeat(o_repeat), .o_elem_strobe(o_elem_strobe),
    .o_count(o_count), .o_charged(o_charged));
  lsc_dp_model i_dp (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_elem_strobe(o_elem_strobe), .i_pattern(pattern), .o_zero_flag(zf));

  // ==========================================================
  // shared helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (e !== g)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // decode fields held after the last instruction
  task automatic fields(input logic [2:0] fm, input logic [1:0] ib, xf,
    input logic mo, fo, rp);
    chk("form", 16'(fm), 16'(o_form));
    chk("imm_bytes", 16'(ib), 16'(o_imm_bytes));
    chk("xfers", 16'(xf), 16'(o_xfers));
    chk("mem", 16'(mo), 16'(o_mem_operand));
    chk("flags_only", 16'(fo), 16'(o_flags_only));
    chk("repeat", 16'(rp), 16'(o_repeat));
  endtask

  task automatic run(input logic pv, input logic [7:0] pf, op, mr, input logic [15:0] cnt,
    ec, input logic [3:0] eo, input logic ew, input logic [15:0] ek);
    logic [15:0] nb, ns;
    nb = 0;
    ns = 0;
    i_prefix_valid = pv;
    i_prefix = pf;
    i_opcode = op;
    i_modrm = mr;
    i_count = cnt;
    i_start = 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge i_mclk);
      #1;
      if (o_elem_strobe === 1'b1) ns++;
      if (o_done === 1'b1) break;
      // start is left alone at the done edge so the next call drives it once
      i_start = (i == poke) ? 1'b1 : 1'b0;
      if (o_busy === 1'b1) nb++;
    end
    chk("charged", ec, o_charged);
    chk("busy", ec, nb);
    chk("op", 16'(eo), 16'(o_op));
    chk("word", 16'(ew), 16'(o_word));
    chk("strobes", ek, ns);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_test;
    run(0, 8'h00, 8'h84, 8'hC0, 0, 3, lsc_pkg::OP_TEST, 0, 0);
    run(0, 8'h00, 8'h85, 8'h06, 0, 14, lsc_pkg::OP_TEST, 1, 0);
    fields(lsc_pkg::FORM_RM_REG, 2'h0, 2'h1, 1'b1, 1'b1, 1'b0);
    run(0, 8'h00, 8'hF6, 8'hC0, 0, 4, lsc_pkg::OP_TEST, 0, 0);
    run(0, 8'h00, 8'hF7, 8'h06, 0, 14, lsc_pkg::OP_TEST, 1, 0);
    fields(lsc_pkg::FORM_IMM_RM, 2'h2, 2'h1, 1'b1, 1'b1, 1'b0);
    run(0, 8'h00, 8'hA8, 8'h00, 0, 3, lsc_pkg::OP_TEST, 0, 0);
    fields(lsc_pkg::FORM_IMM_ACC, 2'h1, 2'h0, 1'b0, 1'b1, 1'b0);
    run(0, 8'h00, 8'hA9, 8'h00, 0, 4, lsc_pkg::OP_TEST, 1, 0);
    run(1, 8'hF2, 8'h84, 8'hC0, 5, 3, lsc_pkg::OP_TEST, 0, 0);
    fields(lsc_pkg::FORM_RM_REG, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic t_or_xor;
    run(0, 8'h00, 8'h08, 8'hC0, 0, 3, lsc_pkg::OP_OR, 0, 0);
    chk("dest", 16'h0000, 16'(o_reg_dest));
    run(0, 8'h00, 8'h0A, 8'h06, 0, 10, lsc_pkg::OP_OR, 0, 0);
    chk("dest", 16'h0001, 16'(o_reg_dest));
    run(0, 8'h00, 8'h09, 8'h06, 0, 18, lsc_pkg::OP_OR, 1, 0);
    fields(lsc_pkg::FORM_RM_REG, 2'h0, 2'h2, 1'b1, 1'b0, 1'b0);
    run(0, 8'h00, 8'h80, 8'hC8, 0, 4, lsc_pkg::OP_OR, 0, 0);
    run(0, 8'h00, 8'h81, 8'h0E, 0, 24, lsc_pkg::OP_OR, 1, 0);
    fields(lsc_pkg::FORM_IMM_RM, 2'h2, 2'h2, 1'b1, 1'b0, 1'b0);
    run(0, 8'h00, 8'h0D, 8'h00, 0, 4, lsc_pkg::OP_OR, 1, 0);
    run(0, 8'h00, 8'h30, 8'hC0, 0, 3, lsc_pkg::OP_XOR, 0, 0);
    run(0, 8'h00, 8'h80, 8'hF0, 0, 4, lsc_pkg::OP_XOR, 0, 0);
    run(0, 8'h00, 8'h34, 8'h00, 0, 3, lsc_pkg::OP_XOR, 0, 0);
  endtask

  task automatic t_not_call;
    run(0, 8'h00, 8'hF6, 8'hD0, 0, 3, lsc_pkg::OP_NOT, 0, 0);
    run(0, 8'h00, 8'hF7, 8'h16, 0, 18, lsc_pkg::OP_NOT, 1, 0);
    fields(lsc_pkg::FORM_RM_ONLY, 2'h0, 2'h2, 1'b1, 1'b0, 1'b0);
    run(0, 8'h00, 8'hFF, 8'hD0, 0, 21, lsc_pkg::OP_CALL, 1, 0);
    run(0, 8'h00, 8'hFF, 8'h16, 0, 35, lsc_pkg::OP_CALL, 1, 0);
    fields(lsc_pkg::FORM_INDIRECT, 2'h0, 2'h2, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_strings;
    run(0, 8'h00, 8'hA4, 8'h00, 0, 14, lsc_pkg::OP_MOVE, 0, 0);
    run(0, 8'h00, 8'hA5, 8'h00, 0, 22, lsc_pkg::OP_MOVE, 1, 0);
    run(0, 8'h00, 8'hA7, 8'h00, 0, 30, lsc_pkg::OP_COMPARE, 1, 0);
    fields(lsc_pkg::FORM_STRING, 2'h0, 2'h2, 1'b1, 1'b1, 1'b0);
    run(0, 8'h00, 8'hAE, 8'h00, 0, 15, lsc_pkg::OP_SCAN, 0, 0);
    run(0, 8'h00, 8'hAD, 8'h00, 0, 16, lsc_pkg::OP_LOAD, 1, 0);
    run(0, 8'h00, 8'hAA, 8'h00, 0, 10, lsc_pkg::OP_STORE, 0, 0);
    run(0, 8'h00, 8'h6D, 8'h00, 0, 18, lsc_pkg::OP_PORT_IN, 1, 0);
    run(0, 8'h00, 8'h6E, 8'h00, 0, 14, lsc_pkg::OP_PORT_OUT, 0, 0);
  endtask

  task automatic t_repeat;
    run(1, 8'hF2, 8'hA4, 8'h00, 2, 24, lsc_pkg::OP_MOVE, 0, 2);
    fields(lsc_pkg::FORM_STRING, 2'h0, 2'h2, 1'b1, 1'b0, 1'b1);
    chk("count", 16'h0000, o_count);
    run(1, 8'hF2, 8'hA5, 8'h00, 3, 56, lsc_pkg::OP_MOVE, 1, 3);
    run(1, 8'hF2, 8'hA4, 8'h00, 0, 8, lsc_pkg::OP_MOVE, 0, 0);
    run(1, 8'hF2, 8'hAB, 8'h00, 2, 32, lsc_pkg::OP_STORE, 1, 2);
    pattern = 8'h01;
    run(1, 8'hF3, 8'hA6, 8'h00, 4, 49, lsc_pkg::OP_COMPARE, 0, 2);
    pattern = 8'h04;
    run(1, 8'hF2, 8'hAE, 8'h00, 5, 50, lsc_pkg::OP_SCAN, 0, 3);
    chk("count", 16'h0002, o_count);
  endtask

  task automatic t_refused;
    poke = 3;
    run(0, 8'h00, 8'hA4, 8'h00, 0, 14, lsc_pkg::OP_MOVE, 0, 0);
    poke = -1;
    i_opcode = 8'h90;
    i_start = 1'b1;
    @(posedge i_mclk);
    #1;
    i_start = 1'b0;
    chk("unsupported", 16'h0001, 16'(o_unsupported));
    chk("idle", 16'h0000, 16'(o_busy));
    @(posedge i_mclk);
    #1;
  endtask

  // ==========================================================
  // clock, reset, sequence and watchdog
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  initial
  begin
    {i_rst_b, i_start, i_prefix_valid} = 3'h0;
    {i_prefix, i_opcode, i_modrm, pattern} = 32'h0000_0000;
    i_count = 16'h0000;
    repeat (8) @(posedge i_mclk);
    #1;
    i_rst_b = 1'b1;
    // one idle cycle after release before the first start
    @(posedge i_mclk);
    #1;
    t_test();
    t_or_xor();
    t_not_call();
    t_strings();
    t_repeat();
    t_refused();
    final_report();
  end

  initial
  begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule // lsc_decode_test

`default_nettype wire

// ==== tb/lsc_dp_model.sv ====
/*
  lsc_dp_model: datapath stand-in that returns a zero flag per element.
  Assumes the decoder strobes once per finished element.
*/
`default_nettype none

module lsc_dp_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic       i_elem_strobe,
  input  wire logic [7:0] i_pattern,
  output logic            o_zero_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] idx;
  logic [2:0] next_idx;

  // ==========================================================
  // element index restarts at each start
  always_comb
  begin
    next_idx = i_start ? 3'h0 : idx + 3'(i_elem_strobe);
  end

  always_ff @(posedge i_mclk)
  begin
    idx <= i_rst_b ? next_idx : 3'h0;
  end

  assign o_zero_flag = i_pattern[idx];
endmodule // lsc_dp_model

`default_nettype wire
